// file: uep_defs.svh
/*
 * Register offsets, field positions, reset values and interrupt bit
 * positions for the endpoint control block.
 * Assumes a 32-bit APB with an 8-bit byte address.
 */
`ifndef UEP_DEFS_SVH
`define UEP_DEFS_SVH
// ****************************************************************
// register map
// ****************************************************************
`define UEP_OFF_CTRL 8'h00
`define UEP_OFF_STAT 8'h20
`define UEP_OFF_CNT 8'h40
`define UEP_OFF_IRQ_STAT 8'h60
`define UEP_OFF_IRQ_MASK 8'h64
// ****************************************************************
// endpoint control fields
// ****************************************************************
`define UEP_CTRL_HSHK 4
`define UEP_CTRL_CONDIS 3
`define UEP_CTRL_OUTEN 2
`define UEP_CTRL_INEN 1
`define UEP_CTRL_STALL 0
`define UEP_CTRL_RST 5'h00
// ****************************************************************
// descriptor status fields
// ****************************************************************
`define UEP_STAT_OWN 7
`define UEP_STAT_TOGGLE 6
`define UEP_STAT_SYNC_EN 3
`define UEP_STAT_BUF_STALL 2
`define UEP_STAT_RST 8'h00
`define UEP_CNT_RST 8'h00
// ****************************************************************
// interrupt status bits
// ****************************************************************
`define UEP_IRQ_STALL 0
`define UEP_IRQ_SETUP 1
`define UEP_IRQ_DONE 2
`define UEP_IRQ_TOGERR 3
`define UEP_IRQ_RST 4'h0
`endif

// file: uep_pkg.sv
/*
 * Types shared by the endpoint control block.
 * Assumes nothing beyond a SystemVerilog tool.
 */
package uep_pkg;
  // token kinds handed over by the serial interface engine
  typedef enum logic [1:0] {
    UEP_PID_OUT,
    UEP_PID_IN,
    UEP_PID_SETUP
  } uep_pid_type;
  // answer the engine gives to the host
  typedef enum logic [2:0] {
    UEP_RESP_NONE,
    UEP_RESP_ACK,
    UEP_RESP_NAK,
    UEP_RESP_STALL,
    UEP_RESP_DATA
  } uep_resp_type;
endpackage

// file: uep_dec_if.sv
/*
 * Carrier between the register top and the token decision logic.
 * Assumes the top drives the token side and reads the decision.
 */
interface uep_dec_if;
  logic tok_valid;
  uep_pkg::uep_pid_type pid;
  logic toggle;
  logic [4:0] ctrl;
  logic [7:0] stat;
  uep_pkg::uep_resp_type resp;
  logic set_stall;
  logic done;
  logic tog_err;
  modport eng (input tok_valid, pid, toggle, ctrl, stat,
               output resp, set_stall, done, tog_err);
  modport top (output tok_valid, pid, toggle, ctrl, stat,
               input resp, set_stall, done, tog_err);
endinterface

// file: uep_apb_slave.sv
/*
 * APB slave handshake: one wait state, registered answer.
 * Assumes the top supplies read data and a hit flag combinationally.
 */
module uep_apb_slave (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] rd_data,
  input wire logic hit,
  output logic pready_r,
  output logic [31:0] prdata_r,
  output logic pslverr_r,
  output logic wr_en
);
  // answer one cycle into the access phase
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      pready_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
      pslverr_r <= 1'b0;
    end
    else
    begin
      pready_r <= psel & penable & ~pready_r;
      prdata_r <= (psel & penable & ~pready_r & ~pwrite) ? rd_data : 32'h0000_0000;
      pslverr_r <= psel & penable & ~pready_r & ~hit;
    end
  end

  // write lands at the edge that samples pready high
  assign wr_en = psel & penable & pready_r & pwrite & hit;
endmodule

// file: uep_tok_engine.sv
/*
 * Decides the answer to one token from the endpoint and descriptor bits.
 * Assumes the top presents the addressed endpoint's registers.
 */
`include "uep_defs.svh"
module uep_tok_engine (
  uep_dec_if.eng dec
);
  logic hshk, condis, out_en, in_en, stall, own, tog_bit, sync_en, buf_stall, is_out, is_in;
  assign hshk = dec.ctrl[`UEP_CTRL_HSHK];
  assign condis = dec.ctrl[`UEP_CTRL_CONDIS];
  assign out_en = dec.ctrl[`UEP_CTRL_OUTEN];
  assign in_en = dec.ctrl[`UEP_CTRL_INEN];
  assign stall = dec.ctrl[`UEP_CTRL_STALL] & (out_en | in_en); // see R8
  assign own = dec.stat[`UEP_STAT_OWN];
  assign tog_bit = dec.stat[`UEP_STAT_TOGGLE];
  assign sync_en = dec.stat[`UEP_STAT_SYNC_EN];
  assign buf_stall = dec.stat[`UEP_STAT_BUF_STALL];
  assign is_out = dec.pid == uep_pkg::UEP_PID_OUT;
  assign is_in = dec.pid == uep_pkg::UEP_PID_IN;

  // priority: refusal, stall, ownership, buffer stall, toggle, transfer
  always_comb
  begin
    uep_pkg::uep_resp_type r;
    r = uep_pkg::UEP_RESP_NONE;
    dec.done = 1'b0;
    dec.tog_err = 1'b0;
    if (!dec.tok_valid)
      r = uep_pkg::UEP_RESP_NONE;
    else if (dec.pid == uep_pkg::UEP_PID_SETUP && (condis || !(out_en && in_en)))
      r = uep_pkg::UEP_RESP_NONE; // see R3
    else if ((is_out && !out_en) || (is_in && !in_en))
      r = uep_pkg::UEP_RESP_NONE; // see R5 see R6
    else if (stall && dec.pid != uep_pkg::UEP_PID_SETUP)
      r = uep_pkg::UEP_RESP_STALL;
    else if (!own)
      r = uep_pkg::UEP_RESP_NAK; // see R13
    else if (buf_stall)
      r = uep_pkg::UEP_RESP_STALL; // see R15
    else if (is_out && sync_en && dec.toggle != tog_bit)
    begin
      r = uep_pkg::UEP_RESP_ACK; // see R14
      dec.tog_err = 1'b1;
    end
    else
    begin
      r = is_in ? uep_pkg::UEP_RESP_DATA : uep_pkg::UEP_RESP_ACK;
      dec.done = 1'b1;
    end
    dec.set_stall = r == uep_pkg::UEP_RESP_STALL; // see R7
    // isochronous: no handshake packets at all
    if (!hshk && r != uep_pkg::UEP_RESP_DATA)
      r = uep_pkg::UEP_RESP_NONE; // see R2
    dec.resp = r;
  end
endmodule

// file: uep_top.sv
/*
 * Endpoint control and buffer descriptor status block.
 * Assumes one 100 MHz clock, synchronous reset and a token source that
 * presents at most one token per cycle as a one-cycle pulse.
 */
// Added by the designer: the register addresses and the APB interface to the registers.
// Behaviour
// R1: eight endpoints, identical control registers each
// R2: handshake enable bit 4 gates handshakes
// R3: control disable bit 3 refuses SETUP
// R4: firmware sets both enables for IN/OUT
// R5: OUT served only with bit 2 set
// R6: IN served only with bit 1 set
// R7: issued STALL sets sticky stall bit 0
// R8: stall bit ignored on disabled endpoint
// R9: bits 7:5 read zero; others reset zero
// R10: firmware initialises ownership before use
// R11: toggle bit picks DATA1/DATA0 under sync
// R12: firmware keeps status bits 5:4 zero
// R13: ownership zero: engine leaves descriptor alone
// R14: toggle mismatch ignored, SETUP excepted
// R15: byte count high bits; buffer stall
`include "uep_defs.svh"
module uep_top (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic tok_valid,
  input wire uep_pkg::uep_pid_type tok_pid,
  input wire logic [2:0] tok_ep,
  input wire logic tok_toggle,
  input wire logic [9:0] tok_count,
  output logic resp_valid,
  output uep_pkg::uep_resp_type resp_code,
  output logic resp_toggle,
  output logic [9:0] resp_count,
  output logic irq
);
  // ****************************************************************
  // storage
  // ****************************************************************
  logic [4:0] ctrl_r [8];
  logic [7:0] stat_r [8];
  logic [7:0] cnt_r [8];
  logic [3:0] irq_stat_r;
  logic [3:0] irq_mask_r;
  logic resp_valid_r;
  uep_pkg::uep_resp_type resp_code_r;
  logic resp_toggle_r;
  logic [9:0] resp_count_r;
  logic irq_r;
  logic wr_en;
  logic hit;
  logic [31:0] rd_data;
  logic [3:0] irq_set;
  logic [3:0] irq_stat_nxt;
  uep_dec_if dec ();

  // ****************************************************************
  // bus slave
  // ****************************************************************
  uep_apb_slave u_apb (
    .ref_clk(ref_clk),
    .rst(rst),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .rd_data(rd_data),
    .hit(hit),
    .pready_r(pready),
    .prdata_r(prdata),
    .pslverr_r(pslverr),
    .wr_en(wr_en)
  );

  // address decode and read mux, word aligned
  always_comb
  begin
    hit = 1'b0;
    rd_data = 32'h0000_0000;
    if (paddr[1:0] == 2'h0)
    begin
      if (paddr[7:5] == `UEP_OFF_CTRL >> 5)
      begin
        hit = 1'b1;
        rd_data = {27'h0000000, ctrl_r[paddr[4:2]]}; // see R9
      end
      else if (paddr[7:5] == `UEP_OFF_STAT >> 5)
      begin
        hit = 1'b1;
        rd_data = {24'h000000, stat_r[paddr[4:2]]};
      end
      else if (paddr[7:5] == `UEP_OFF_CNT >> 5)
      begin
        hit = 1'b1;
        rd_data = {24'h000000, cnt_r[paddr[4:2]]};
      end
      else if (paddr == `UEP_OFF_IRQ_STAT)
      begin
        hit = 1'b1;
        rd_data = {28'h0000000, irq_stat_r};
      end
      else if (paddr == `UEP_OFF_IRQ_MASK)
      begin
        hit = 1'b1;
        rd_data = {28'h0000000, irq_mask_r};
      end
    end
  end

  // ****************************************************************
  // token decision
  // ****************************************************************
  assign dec.tok_valid = tok_valid;
  assign dec.pid = tok_pid;
  assign dec.toggle = tok_toggle;
  assign dec.ctrl = ctrl_r[tok_ep];
  assign dec.stat = stat_r[tok_ep];

  uep_tok_engine u_eng (
    .dec(dec.eng)
  );

  // ****************************************************************
  // per endpoint registers
  // ****************************************************************
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++)
    begin : g_ep
      logic sel;
      logic wr_ctrl, wr_stat, wr_cnt;
      assign sel = tok_ep == 3'(gi);
      assign wr_ctrl = wr_en && paddr[7:5] == `UEP_OFF_CTRL >> 5 && paddr[4:2] == 3'(gi);
      assign wr_stat = wr_en && paddr[7:5] == `UEP_OFF_STAT >> 5 && paddr[4:2] == 3'(gi);
      assign wr_cnt = wr_en && paddr[7:5] == `UEP_OFF_CNT >> 5 && paddr[4:2] == 3'(gi);

      // control: firmware write, engine stall set wins
      always_ff @(posedge ref_clk)
      begin
        if (rst)
          ctrl_r[gi] <= `UEP_CTRL_RST; // see R9
        else
        begin
          if (wr_ctrl)
            ctrl_r[gi] <= pwdata[4:0]; // see R1
          if (sel && dec.set_stall)
            ctrl_r[gi][`UEP_CTRL_STALL] <= 1'b1; // see R7
        end
      end

      // descriptor status: engine update wins over firmware write
      always_ff @(posedge ref_clk)
      begin
        if (rst)
          stat_r[gi] <= `UEP_STAT_RST;
        else if (sel && dec.done)
        begin
          stat_r[gi][`UEP_STAT_OWN] <= 1'b0; // see R13
          stat_r[gi][`UEP_STAT_TOGGLE] <= ~stat_r[gi][`UEP_STAT_TOGGLE];
          if (tok_pid == uep_pkg::UEP_PID_OUT)
            stat_r[gi][1:0] <= tok_count[9:8]; // see R15
        end
        else if (wr_stat)
          stat_r[gi] <= {pwdata[7:6], 2'h0, pwdata[3:0]};
      end

      // low byte count
      always_ff @(posedge ref_clk)
      begin
        if (rst)
          cnt_r[gi] <= `UEP_CNT_RST;
        else if (sel && dec.done && tok_pid == uep_pkg::UEP_PID_OUT)
          cnt_r[gi] <= tok_count[7:0];
        else if (wr_cnt)
          cnt_r[gi] <= pwdata[7:0];
      end
    end
  endgenerate

  // ****************************************************************
  // answer to the host
  // ****************************************************************
  // registered answer, one cycle after the token
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      resp_valid_r <= 1'b0;
      resp_code_r <= uep_pkg::UEP_RESP_NONE;
      resp_toggle_r <= 1'b0;
      resp_count_r <= 10'h000;
    end
    else
    begin
      resp_valid_r <= tok_valid;
      resp_code_r <= dec.resp;
      resp_toggle_r <= dec.stat[`UEP_STAT_TOGGLE]; // see R11
      resp_count_r <= {dec.stat[1:0], cnt_r[tok_ep]}; // see R15
    end
  end

  assign resp_valid = resp_valid_r;
  assign resp_code = resp_code_r;
  assign resp_toggle = resp_toggle_r;
  assign resp_count = resp_count_r;

  // ****************************************************************
  // interrupts
  // ****************************************************************
  assign irq_set[`UEP_IRQ_STALL] = dec.set_stall;
  assign irq_set[`UEP_IRQ_SETUP] = dec.done && tok_pid == uep_pkg::UEP_PID_SETUP;
  assign irq_set[`UEP_IRQ_DONE] = dec.done;
  assign irq_set[`UEP_IRQ_TOGERR] = dec.tog_err;

  // write one to clear, set wins
  always_comb
  begin
    irq_stat_nxt = irq_stat_r;
    if (wr_en && paddr == `UEP_OFF_IRQ_STAT)
      irq_stat_nxt = irq_stat_nxt & ~pwdata[3:0];
    irq_stat_nxt = irq_stat_nxt | irq_set;
  end

  // sticky status and mask
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      irq_stat_r <= `UEP_IRQ_RST;
      irq_mask_r <= `UEP_IRQ_RST;
    end
    else
    begin
      irq_stat_r <= irq_stat_nxt;
      if (wr_en && paddr == `UEP_OFF_IRQ_MASK)
        irq_mask_r <= pwdata[3:0];
    end
  end

  // level interrupt output
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      irq_r <= 1'b0;
    else
      irq_r <= |(irq_stat_r & irq_mask_r);
  end

  assign irq = irq_r;

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  logic [4:0] t_ctrl;
  logic [7:0] t_stat;
  assign t_ctrl = ctrl_r[tok_ep];
  assign t_stat = stat_r[tok_ep];

  property p_ctrl_read_zero;
    pready && psel && !pwrite && paddr[7:5] == 3'h0 && paddr[1:0] == 2'h0
      |-> prdata[31:5] == 27'h0000000;
  endproperty
  a_ctrl_read_zero: assert property (p_ctrl_read_zero) else $error("ctrl upper bits nonzero"); // see R9

  property p_hshk_off;
    tok_valid && !t_ctrl[`UEP_CTRL_HSHK]
      |=> resp_code inside {uep_pkg::UEP_RESP_NONE, uep_pkg::UEP_RESP_DATA};
  endproperty
  a_hshk_off: assert property (p_hshk_off) else $error("handshake sent while disabled"); // see R2

  property p_setup_refused;
    tok_valid && tok_pid == uep_pkg::UEP_PID_SETUP && t_ctrl[`UEP_CTRL_CONDIS]
      |=> resp_valid && resp_code == uep_pkg::UEP_RESP_NONE;
  endproperty
  a_setup_refused: assert property (p_setup_refused) else $error("setup accepted"); // see R3

  property p_out_off;
    tok_valid && tok_pid == uep_pkg::UEP_PID_OUT && !t_ctrl[`UEP_CTRL_OUTEN]
      |=> resp_code == uep_pkg::UEP_RESP_NONE;
  endproperty
  a_out_off: assert property (p_out_off) else $error("out served while disabled"); // see R5

  property p_in_off;
    tok_valid && tok_pid == uep_pkg::UEP_PID_IN && !t_ctrl[`UEP_CTRL_INEN]
      |=> resp_code == uep_pkg::UEP_RESP_NONE;
  endproperty
  a_in_off: assert property (p_in_off) else $error("in served while disabled"); // see R6

  property p_stall_sticky;
    // endpoint 7 is the one the buffer stall scenario flags
    ctrl_r[7][`UEP_CTRL_STALL] && !(wr_en && paddr == `UEP_OFF_CTRL + 8'h1C)
      |=> ctrl_r[7][`UEP_CTRL_STALL];
  endproperty
  a_stall_sticky: assert property (p_stall_sticky) else $error("stall flag lost"); // see R7

  property p_stall_issue;
    tok_valid && t_ctrl[`UEP_CTRL_HSHK] && dec.set_stall
      |=> resp_code == uep_pkg::UEP_RESP_STALL && ctrl_r[$past(tok_ep)][`UEP_CTRL_STALL];
  endproperty
  a_stall_issue: assert property (p_stall_issue) else $error("stall not recorded"); // see R7

  property p_stall_disabled;
    tok_valid && !t_ctrl[`UEP_CTRL_OUTEN] && !t_ctrl[`UEP_CTRL_INEN]
      |=> resp_code != uep_pkg::UEP_RESP_STALL;
  endproperty
  a_stall_disabled: assert property (p_stall_disabled) else $error("stall on disabled ep"); // see R8

  property p_core_owned;
    tok_valid && !t_stat[`UEP_STAT_OWN]
      |=> stat_r[$past(tok_ep)] == $past(t_stat) || $past(wr_en);
  endproperty
  a_core_owned: assert property (p_core_owned) else $error("descriptor touched"); // see R13

  property p_toggle_drop;
    tok_valid && tok_pid == uep_pkg::UEP_PID_OUT && t_stat[`UEP_STAT_SYNC_EN] &&
      t_stat[`UEP_STAT_TOGGLE] != tok_toggle && !wr_en
      |=> stat_r[$past(tok_ep)][`UEP_STAT_OWN] == $past(t_stat[`UEP_STAT_OWN]);
  endproperty
  a_toggle_drop: assert property (p_toggle_drop) else $error("mismatched data taken"); // see R14

  property p_in_toggle;
    resp_code == uep_pkg::UEP_RESP_DATA |-> resp_toggle == $past(t_stat[`UEP_STAT_TOGGLE]);
  endproperty
  a_in_toggle: assert property (p_in_toggle) else $error("wrong data pid"); // see R11

  property p_irq_level;
    |(irq_stat_r & irq_mask_r) |=> irq ##1 (irq || !$past(|(irq_stat_r & irq_mask_r)));
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("irq not raised");

  c_setup: cover property (tok_valid && tok_pid == uep_pkg::UEP_PID_SETUP ##1
    resp_code == uep_pkg::UEP_RESP_ACK);
  c_in_data: cover property (resp_code == uep_pkg::UEP_RESP_DATA);
  c_stall: cover property (dec.set_stall ##1 irq_stat_r[`UEP_IRQ_STALL]);
  c_irq: cover property (irq ##[1:20] !irq);
endmodule

// file: uep_host_model.sv
/*
 * Token source standing for the host side of the serial interface engine.
 * Assumes the bench calls send() and reads the got_* results afterwards.
 */
module uep_host_model (
  input wire logic ref_clk,
  output logic tok_valid,
  output uep_pkg::uep_pid_type tok_pid,
  output logic [2:0] tok_ep,
  output logic tok_toggle,
  output logic [9:0] tok_count,
  input wire logic resp_valid,
  input wire uep_pkg::uep_resp_type resp_code,
  input wire logic resp_toggle,
  input wire logic [9:0] resp_count
);
  timeunit 1ns;
  timeprecision 1ps;
  logic got_valid;
  uep_pkg::uep_resp_type got_code;
  logic got_toggle;
  logic [9:0] got_count;
  // quiet token lines at time zero
  initial
  begin
    tok_valid = 1'b0;
    tok_pid = uep_pkg::UEP_PID_OUT;
    tok_ep = 3'h0;
    tok_toggle = 1'b0;
    tok_count = 10'h000;
  end
  // one token pulse, answer taken in the following cycle
  task automatic send(input uep_pkg::uep_pid_type pid, input logic [2:0] ep, input logic tog,
                      input logic [9:0] cnt);
    @(posedge ref_clk);
    tok_valid <= 1'b1;
    tok_pid <= pid;
    tok_ep <= ep;
    tok_toggle <= tog;
    tok_count <= cnt;
    @(posedge ref_clk);
    tok_valid <= 1'b0;
    tok_ep <= ~ep; // qualifiers no longer hold once the pulse is gone
    tok_toggle <= ~tog;
    tok_count <= ~cnt;
    #1;
    got_valid = resp_valid;
    got_code = resp_code;
    got_toggle = resp_toggle;
    got_count = resp_count;
  endtask
endmodule

// file: uep_top_tb.sv
/*
 * Self-checking bench for the endpoint control block: APB register tasks
 * and token sequences with expected answers.
 * Assumes the host model drives the token port.
 */
`include "uep_defs.svh"
module uep_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk, rst, psel, penable, pwrite, pready, pslverr, irq;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic tok_valid, tok_toggle, resp_valid, resp_toggle, e;
  uep_pkg::uep_pid_type tok_pid;
  uep_pkg::uep_resp_type resp_code;
  logic [2:0] tok_ep;
  logic [9:0] tok_count, resp_count;
  int failures = 0;
  int num_checks = 0;
  int cycles = 0;
  // ****************************************************************
  // clock, reset, instances
  // ****************************************************************
  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  uep_top i_uep_top (.ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .tok_valid(tok_valid), .tok_pid(tok_pid), .tok_ep(tok_ep),
    .tok_toggle(tok_toggle), .tok_count(tok_count), .resp_valid(resp_valid),
    .resp_code(resp_code), .resp_toggle(resp_toggle), .resp_count(resp_count), .irq(irq));
  uep_host_model i_uep_host_model (.ref_clk(ref_clk), .tok_valid(tok_valid),
    .tok_pid(tok_pid), .tok_ep(tok_ep), .tok_toggle(tok_toggle), .tok_count(tok_count),
    .resp_valid(resp_valid), .resp_code(resp_code), .resp_toggle(resp_toggle),
    .resp_count(resp_count));
  // ****************************************************************
  // tasks
  // ****************************************************************
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one APB transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] rq, output logic re);
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    // no fixed wait: only the hang guard ends a stuck access
    do
      @(posedge ref_clk);
    while (pready !== 1'b1);
    rq = prdata;
    re = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, q, e);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0, q, e);
    chk(q, exp);
  endtask
  function automatic logic [7:0] ra(input logic [7:0] base, input int n);
    return 8'(base + 4 * n);
  endfunction
  task automatic tok(input uep_pkg::uep_pid_type p, input int n, input logic t,
                     input logic [9:0] c, input uep_pkg::uep_resp_type exp);
    i_uep_host_model.send(p, 3'(n), t, c);
    chk({31'h0, i_uep_host_model.got_valid}, 32'h1);
    chk({29'h0, i_uep_host_model.got_code}, {29'h0, exp});
  endtask
  // hang guard
  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      failures++;
      wrap_up();
    end
  end
  // ****************************************************************
  // test sequence
  // ****************************************************************
  initial
  begin
    rst = 1'b1;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    repeat (8) @(posedge ref_clk);
    rst <= 1'b0;
    for (int n = 0; n < 8; n++)
    begin
      rd(ra(`UEP_OFF_CTRL, n), 32'h0);
      rd(ra(`UEP_OFF_STAT, n), 32'h0);
    end
    rd(`UEP_OFF_IRQ_STAT, 32'h0);
    $display("test reset done");
    // upper bits dropped, each endpoint keeps its own value
    for (int n = 0; n < 8; n++)
      wr(ra(`UEP_OFF_CTRL, n), 32'hFFFFFFF0 | n);
    for (int n = 0; n < 8; n++)
      rd(ra(`UEP_OFF_CTRL, n), 32'h10 | n);
    apb(1'b0, 8'h80, 32'h0, q, e);
    chk({q[30:0], e}, 32'h1);
    apb(1'b1, 8'h02, 32'hFF, q, e);
    chk({31'h0, e}, 32'h1);
    rd(ra(`UEP_OFF_CTRL, 0), 32'h10);
    $display("test registers done");
    // refusals; descriptors owned by the engine first
    for (int n = 0; n < 8; n++)
      wr(ra(`UEP_OFF_STAT, n), 32'h80);
    wr(ra(`UEP_OFF_CTRL, 2), 32'h12);
    tok(uep_pkg::UEP_PID_OUT, 2, 1'b0, 10'h1, uep_pkg::UEP_RESP_NONE);
    wr(ra(`UEP_OFF_CTRL, 3), 32'h1E);
    tok(uep_pkg::UEP_PID_SETUP, 3, 1'b0, 10'h8, uep_pkg::UEP_RESP_NONE);
    wr(ra(`UEP_OFF_CTRL, 4), 32'h14);
    tok(uep_pkg::UEP_PID_IN, 4, 1'b0, 10'h0, uep_pkg::UEP_RESP_NONE);
    wr(ra(`UEP_OFF_CTRL, 5), 32'h16);
    wr(ra(`UEP_OFF_STAT, 5), 32'h00);
    tok(uep_pkg::UEP_PID_OUT, 5, 1'b0, 10'h1, uep_pkg::UEP_RESP_NAK);
    wr(ra(`UEP_OFF_CTRL, 5), 32'h06);
    tok(uep_pkg::UEP_PID_OUT, 5, 1'b0, 10'h1, uep_pkg::UEP_RESP_NONE);
    wr(ra(`UEP_OFF_CTRL, 6), 32'h17);
    tok(uep_pkg::UEP_PID_IN, 6, 1'b0, 10'h0, uep_pkg::UEP_RESP_STALL);
    wr(ra(`UEP_OFF_CTRL, 6), 32'h11);
    tok(uep_pkg::UEP_PID_IN, 6, 1'b0, 10'h0, uep_pkg::UEP_RESP_NONE);
    $display("test refusals done");
    // buffer stall raises the sticky flag, descriptor untouched
    wr(ra(`UEP_OFF_CTRL, 7), 32'h16);
    wr(ra(`UEP_OFF_STAT, 7), 32'h84);
    tok(uep_pkg::UEP_PID_OUT, 7, 1'b0, 10'h5, uep_pkg::UEP_RESP_STALL);
    rd(ra(`UEP_OFF_CTRL, 7), 32'h17);
    rd(ra(`UEP_OFF_STAT, 7), 32'h84);
    wr(ra(`UEP_OFF_CTRL, 7), 32'h16);
    rd(ra(`UEP_OFF_CTRL, 7), 32'h16);
    // IN data with DATA1 and a 10-bit count
    wr(ra(`UEP_OFF_CTRL, 0), 32'h16);
    wr(ra(`UEP_OFF_STAT, 0), 32'hCB);
    wr(ra(`UEP_OFF_CNT, 0), 32'h20);
    tok(uep_pkg::UEP_PID_IN, 0, 1'b0, 10'h0, uep_pkg::UEP_RESP_DATA);
    chk({31'h0, i_uep_host_model.got_toggle}, 32'h1);
    chk({22'h0, i_uep_host_model.got_count}, 32'h320);
    rd(ra(`UEP_OFF_STAT, 0), 32'h0B);
    // toggle mismatch dropped, SETUP accepted anyway
    wr(ra(`UEP_OFF_CTRL, 1), 32'h16);
    wr(ra(`UEP_OFF_STAT, 1), 32'h88);
    tok(uep_pkg::UEP_PID_OUT, 1, 1'b1, 10'h4, uep_pkg::UEP_RESP_ACK);
    rd(ra(`UEP_OFF_STAT, 1), 32'h88);
    tok(uep_pkg::UEP_PID_SETUP, 1, 1'b1, 10'h8, uep_pkg::UEP_RESP_ACK);
    rd(ra(`UEP_OFF_STAT, 1), 32'h48);
    // OUT completes and stores the received count
    wr(ra(`UEP_OFF_STAT, 1), 32'h80);
    tok(uep_pkg::UEP_PID_OUT, 1, 1'b0, 10'h2AB, uep_pkg::UEP_RESP_ACK);
    rd(ra(`UEP_OFF_STAT, 1), 32'h42);
    rd(ra(`UEP_OFF_CNT, 1), 32'hAB);
    $display("test transfers done");
    // events latched, masked, then cleared by writing one
    rd(`UEP_OFF_IRQ_STAT, 32'hF);
    chk({31'h0, irq}, 32'h0);
    wr(`UEP_OFF_IRQ_MASK, 32'h4);
    repeat (3) @(posedge ref_clk);
    #1;
    chk({31'h0, irq}, 32'h1);
    wr(`UEP_OFF_IRQ_STAT, 32'h4);
    rd(`UEP_OFF_IRQ_STAT, 32'hB);
    rd(`UEP_OFF_IRQ_MASK, 32'h4);
    chk({31'h0, irq}, 32'h0);
    $display("test interrupts done");
    wrap_up();
  end
endmodule
